//--- rtl/line_port_device.sv
// Overview of operation
// - transfer starts on chip select falling
// - input bits sampled on serial clock rise
// - output valid rise if select 1, else fall
// - receive data valid on opposite recovered edge
// - host holds select 50 ns after write
// - read ends anytime, output released immediately
// - last read bit held to edge 16/17
// - output released outside selected read data
// - command first, bit 0 direction, then data
// - only address 16 is answered
// - command bit 7 ignored
// - eight data bits load control word
// - control bits clear, length, loops, ones
// - clear write drops interrupt, reads do not
// - clear updates code and masks source
// - writing zero re-enables source interrupt
// - read shifts status word, lsb first
// - top three bits give mode/change code
// - interrupt low on flag change until cleared
// - serial timing from serial clock only
// - both loops written starts device reset
// - signal loss rise and fall both interrupt
`timescale 1ns/1ps
`default_nettype none
module line_port_device
    import serial_port_pkg::*;
(
    // status-side clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // serial port
    serial_port_if.device port,
    // line status levels from the analog side
    input wire logic signal_loss_in,
    input wire logic driver_fault_in,
    // recovered receive clock and data
    input wire logic rx_clk,
    input wire logic rx_pos_in,
    input wire logic rx_neg_in,
    // line configuration and status
    output logic [2:0] line_length,
    output logic remote_loop_select,
    output logic local_loop_select,
    output logic all_ones_transmit,
    output logic signal_loss_flag,
    output logic driver_fault_flag,
    output logic rx_positive_data,
    output logic rx_negative_data
);
    // serial clock domain
    logic frame_clr;
    logic [4:0] rise_cnt_reg;
    logic [4:0] fall_cnt_reg;
    logic [7:0] cmd_reg;
    logic [7:0] data_reg;
    logic read_reg;
    logic selected_reg;
    logic [7:0] status_snap_reg;
    logic [7:0] status_sclk;
    logic [7:0] wr_hold_reg;
    logic wr_toggle_reg;
    logic rise_bit_reg;
    logic rise_oe_reg;
    logic fall_bit_reg;
    logic fall_oe_reg;
    logic [2:0] fall_idx;
    // status clock domain
    logic [1:0] line_sync;
    logic wr_toggle_sync;
    logic wr_toggle_seen_reg;
    logic wr_event;
    logic [7:0] ctl_word;
    logic dev_reset_req;
    logic loss_prev_reg;
    logic fault_prev_reg;
    logic loss_change;
    logic fault_change;
    logic mask_loss_reg;
    logic mask_fault_reg;
    logic chg_loss_reg;
    logic chg_fault_reg;
    logic int_pend_reg;
    logic [7:0] status_word_reg;
    logic [1:0] rx_rise_reg;
    logic [1:0] rx_fall_reg;

    // a high select holds the frame logic cleared, so only a falling select opens a frame
    assign frame_clr = reset | port.cs_n;

    // the whole frame runs on the serial clock, nothing else
    // shift on rising edges, stop counting after the sixteenth
    always_ff @(posedge port.sclk or posedge frame_clr) begin
        if (frame_clr) begin
            rise_cnt_reg <= 5'h00;
            cmd_reg <= 8'h00;
            data_reg <= 8'h00;
        end else begin
            if (rise_cnt_reg < FRAME_END) begin
                rise_cnt_reg <= rise_cnt_reg + 5'h01;
            end
            if (rise_cnt_reg <= CMD_LAST) begin
                cmd_reg[rise_cnt_reg[2:0]] <= port.serial_in_line;
            end else if (rise_cnt_reg <= DATA_LAST) begin
                data_reg[rise_cnt_reg[2:0]] <= port.serial_in_line;
            end
        end
    end

    // decode on the eighth rise; bit 7 never reaches the compare
    always_ff @(posedge port.sclk or posedge frame_clr) begin
        if (frame_clr) begin
            read_reg <= 1'b0;
            selected_reg <= 1'b0;
            status_snap_reg <= STATUS_RESET;
        end else if (rise_cnt_reg == CMD_LAST) begin
            read_reg <= cmd_reg[CMD_RW_POS] == CMD_READ;
            selected_reg <= cmd_reg[CMD_ADDR_LSB +: 6] == PORT_ADDR;
            status_snap_reg <= status_sclk;
        end
    end

    // status word crosses as settled levels; it is quasi-static and seven edges pass before the snapshot
    bit_sync #(.WIDTH(8)) status_to_sclk (
        .clk(port.sclk),
        .rst(reset),
        .d(status_word_reg),
        .q(status_sclk)
    );

    // the eighth data bit completes the word; it is handed over with a toggle
    always_ff @(posedge port.sclk or posedge reset) begin
        if (reset) begin
            wr_hold_reg <= 8'h00;
            wr_toggle_reg <= 1'b0;
        end else if (rise_cnt_reg == DATA_LAST && selected_reg && !read_reg && !port.cs_n) begin
            wr_hold_reg <= {port.serial_in_line, data_reg[6:0]};
            wr_toggle_reg <= ~wr_toggle_reg;
        end
    end

    // select 0 launches on rises 9..16 and releases on rise 17
    always_ff @(posedge port.sclk or posedge frame_clr) begin
        if (frame_clr) begin
            rise_bit_reg <= 1'b0;
            rise_oe_reg <= 1'b0;
        end else begin
            rise_bit_reg <= status_snap_reg[rise_cnt_reg[2:0]];
            rise_oe_reg <= selected_reg && read_reg && rise_cnt_reg > CMD_LAST && rise_cnt_reg <= DATA_LAST;
        end
    end

    // falling-edge counter, also cleared by a high select
    always_ff @(negedge port.sclk or posedge frame_clr) begin
        if (frame_clr) begin
            fall_cnt_reg <= 5'h00;
        end else if (fall_cnt_reg < FRAME_END) begin
            fall_cnt_reg <= fall_cnt_reg + 5'h01;
        end
    end

    assign fall_idx = 3'(fall_cnt_reg - FALL_FIRST);

    // select 1 launches on falls 8..15 and releases on fall 16
    always_ff @(negedge port.sclk or posedge frame_clr) begin
        if (frame_clr) begin
            fall_bit_reg <= 1'b0;
            fall_oe_reg <= 1'b0;
        end else begin
            fall_bit_reg <= status_snap_reg[fall_idx];
            fall_oe_reg <= selected_reg && read_reg && fall_cnt_reg >= FALL_FIRST && fall_cnt_reg <= FALL_LAST;
        end
    end

    // both enables clear asynchronously with select, so writes and idle stay released
    assign port.serial_out_line = port.edge_select ? fall_bit_reg : rise_bit_reg;
    assign port.serial_out_oe = port.edge_select ? fall_oe_reg : rise_oe_reg;

    // line levels and the write toggle enter the status clock
    bit_sync #(.WIDTH(2)) line_to_sys (
        .clk(sys_clk),
        .rst(reset),
        .d({driver_fault_in, signal_loss_in}),
        .q(line_sync)
    );
    bit_sync #(.WIDTH(1)) write_to_sys (
        .clk(sys_clk),
        .rst(reset),
        .d(wr_toggle_reg),
        .q(wr_toggle_sync)
    );

    // write event; the held word is stable for a whole frame after each toggle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wr_toggle_seen_reg <= 1'b0;
        end else begin
            wr_toggle_seen_reg <= wr_toggle_sync;
        end
    end
    assign wr_event = wr_toggle_sync ^ wr_toggle_seen_reg;
    assign ctl_word = wr_hold_reg;
    // both loop bits together request a reset
    assign dev_reset_req = wr_event && ctl_word[CTL_REMOTE] && ctl_word[CTL_LOCAL];

    // configuration bits drive the line controls
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            line_length <= 3'h0;
            remote_loop_select <= 1'b0;
            local_loop_select <= 1'b0;
            all_ones_transmit <= 1'b0;
        end else if (dev_reset_req) begin
            line_length <= 3'h0;
            remote_loop_select <= 1'b0;
            local_loop_select <= 1'b0;
            all_ones_transmit <= 1'b0;
        end else if (wr_event) begin
            line_length <= ctl_word[CTL_LEN_LSB +: 3];
            remote_loop_select <= ctl_word[CTL_REMOTE];
            local_loop_select <= ctl_word[CTL_LOCAL];
            all_ones_transmit <= ctl_word[CTL_ONES];
        end
    end

    // a change is a line edge that moves the reported flag
    assign loss_change = (line_sync[0] != loss_prev_reg) && (line_sync[0] != signal_loss_flag);
    assign fault_change = (line_sync[1] != fault_prev_reg) && (line_sync[1] != driver_fault_flag);

    // reported flags follow line edges; a device reset forces signal loss high
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            loss_prev_reg <= 1'b0;
            fault_prev_reg <= 1'b0;
            signal_loss_flag <= 1'b1;
            driver_fault_flag <= 1'b0;
        end else begin
            loss_prev_reg <= line_sync[0];
            fault_prev_reg <= line_sync[1];
            if (dev_reset_req) begin
                signal_loss_flag <= 1'b1;
                driver_fault_flag <= 1'b0;
            end else begin
                if (loss_change) begin
                    signal_loss_flag <= line_sync[0];
                end
                if (fault_change) begin
                    driver_fault_flag <= line_sync[1];
                end
            end
        end
    end

    // clear bit at 1 masks its source, at 0 unmasks it
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mask_loss_reg <= 1'b0;
            mask_fault_reg <= 1'b0;
        end else if (dev_reset_req) begin
            mask_loss_reg <= 1'b0;
            mask_fault_reg <= 1'b0;
        end else if (wr_event) begin
            mask_loss_reg <= ctl_word[CTL_LOSS_CLR];
            mask_fault_reg <= ctl_word[CTL_FAULT_CLR];
        end
    end

    // clears first, then unmasked changes set, so a change in the clear cycle wins
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            chg_loss_reg <= 1'b0;
            chg_fault_reg <= 1'b0;
            int_pend_reg <= 1'b0;
        end else begin
            if (dev_reset_req) begin
                chg_loss_reg <= 1'b0;
                chg_fault_reg <= 1'b0;
                int_pend_reg <= 1'b0;
            end else if (wr_event) begin
                if (ctl_word[CTL_LOSS_CLR]) begin
                    chg_loss_reg <= 1'b0;
                end
                if (ctl_word[CTL_FAULT_CLR]) begin
                    chg_fault_reg <= 1'b0;
                end
                if (ctl_word[CTL_LOSS_CLR] || ctl_word[CTL_FAULT_CLR]) begin
                    int_pend_reg <= 1'b0;
                end
            end
            if (loss_change && !mask_loss_reg) begin
                chg_loss_reg <= 1'b1;
                int_pend_reg <= 1'b1;
            end
            if (fault_change && !mask_fault_reg) begin
                chg_fault_reg <= 1'b1;
                int_pend_reg <= 1'b1;
            end
        end
    end

    // open drain, pulled low while pending
    assign port.int_oe = int_pend_reg;

    // status word; change codes take priority over mode codes
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            status_word_reg <= STATUS_RESET;
        end else begin
            status_word_reg[STS_LOSS] <= signal_loss_flag;
            status_word_reg[STS_FAULT] <= driver_fault_flag;
            status_word_reg[STS_LEN_LSB +: 3] <= line_length;
            if (chg_loss_reg || chg_fault_reg) begin
                status_word_reg[STS_CODE0] <= 1'b1;
                status_word_reg[STS_CODE1] <= chg_loss_reg;
                status_word_reg[STS_CODE2] <= chg_fault_reg;
            end else if (remote_loop_select) begin
                status_word_reg[STS_CODE0] <= 1'b1;
                status_word_reg[STS_CODE1] <= 1'b0;
                status_word_reg[STS_CODE2] <= 1'b0;
            end else begin
                status_word_reg[STS_CODE0] <= 1'b0;
                status_word_reg[STS_CODE1] <= local_loop_select;
                status_word_reg[STS_CODE2] <= all_ones_transmit;
            end
        end
    end

    // launch on one recovered edge so data is stable at the other
    always_ff @(posedge rx_clk or posedge reset) begin
        if (reset) begin
            rx_rise_reg <= 2'h0;
        end else begin
            rx_rise_reg <= {rx_neg_in, rx_pos_in};
        end
    end
    always_ff @(negedge rx_clk or posedge reset) begin
        if (reset) begin
            rx_fall_reg <= 2'h0;
        end else begin
            rx_fall_reg <= {rx_neg_in, rx_pos_in};
        end
    end
    assign rx_positive_data = port.edge_select ? rx_rise_reg[0] : rx_fall_reg[0];
    assign rx_negative_data = port.edge_select ? rx_rise_reg[1] : rx_fall_reg[1];
endmodule : line_port_device
`default_nettype wire

//--- rtl/serial_port_pkg.sv
package serial_port_pkg;
    // command byte layout, first bit on the wire is bit 0
    localparam int CMD_BITS = 8;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] DATA_LAST = 5'h0F;
    localparam logic [4:0] FRAME_END = 5'h10;
    localparam logic [4:0] FALL_FIRST = 5'h07;
    localparam logic [4:0] FALL_LAST = 5'h0E;
    localparam int CMD_RW_POS = 0;
    localparam int CMD_ADDR_LSB = 1;
    localparam logic [5:0] PORT_ADDR = 6'h10;
    localparam logic CMD_WRITE = 1'h0;
    localparam logic CMD_READ = 1'h1;
    // control word written over the port (line_control_input)
    localparam logic [7:0] REG_OFFSET = 8'h10;
    localparam int CTL_LOSS_CLR = 0;
    localparam int CTL_FAULT_CLR = 1;
    localparam int CTL_LEN_LSB = 2;
    localparam int CTL_REMOTE = 5;
    localparam int CTL_LOCAL = 6;
    localparam int CTL_ONES = 7;
    // status word read over the port (line_status_output)
    localparam int STS_LOSS = 0;
    localparam int STS_FAULT = 1;
    localparam int STS_LEN_LSB = 2;
    localparam int STS_CODE0 = 5;
    localparam int STS_CODE1 = 6;
    localparam int STS_CODE2 = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // host timing: sys_clk 50 ns, serial half period, chip select hold
    localparam int SYS_CLK_NS = 50;
    localparam int SCLK_HALF_NS = 200;
    localparam int CS_HOLD_NS = 50;
    localparam logic [3:0] HALF_CYCLES = 4'((SCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
    localparam logic [3:0] CS_HOLD_CYCLES = 4'((CS_HOLD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
    localparam logic [3:0] LAST_BIT = 4'hF;
    localparam logic [3:0] FIRST_DATA_BIT = 4'h8;
endpackage : serial_port_pkg

//--- rtl/serial_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface serial_port_if;
    // driven by the host end
    logic cs_n;
    logic sclk;
    logic serial_in_line;
    logic edge_select;
    // driven by the line interface end
    logic serial_out_line;
    logic serial_out_oe;
    logic int_oe;
    // resolved wire levels, pull-ups assumed on both shared lines
    logic serial_out_level;
    logic int_n_level;
    assign serial_out_level = serial_out_oe ? serial_out_line : 1'b1;
    assign int_n_level = int_oe ? 1'b0 : 1'b1;

    modport device (
        input cs_n, sclk, serial_in_line, edge_select,
        output serial_out_line, serial_out_oe, int_oe
    );
    modport host (
        output cs_n, sclk, serial_in_line, edge_select,
        input serial_out_level, int_n_level
    );
endinterface : serial_port_if
`default_nettype wire

//--- rtl/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset of the receiving domain
    input wire logic clk,
    input wire logic rst,
    // asynchronous levels in, settled levels out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds the second stage only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : bit_sync
`default_nettype wire

//--- rtl/line_port_host.sv
`timescale 1ns/1ps
`default_nettype none
module line_port_host
    import serial_port_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // serial port pins
    serial_port_if.host port,
    // user request
    input wire logic req,
    input wire logic req_read,
    input wire logic [7:0] req_wdata,
    input wire logic edge_select_cfg,
    // user answer
    output logic busy,
    output logic done,
    output logic [7:0] rd_data,
    output logic int_active
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LOW = 3'b001,
        H_HIGH = 3'b010,
        H_TAIL = 3'b011,
        H_GAP = 3'b100
    } host_state_type;

    host_state_type state_reg;
    logic [3:0] tick_reg;
    logic [3:0] bit_reg;
    logic [15:0] frame_reg;
    logic read_reg;
    logic [7:0] rd_shift_reg;
    logic cs_n_reg;
    logic sclk_reg;
    logic sdi_reg;
    logic edge_reg;
    logic [1:0] pin_sync;
    logic half_done;
    logic [2:0] rd_idx;

    // device output and interrupt arrive from pins
    bit_sync #(.WIDTH(2)) pins_to_sys (
        .clk(sys_clk),
        .rst(reset),
        .d({~port.int_n_level, port.serial_out_level}),
        .q(pin_sync)
    );

    assign half_done = tick_reg == HALF_CYCLES - 4'h1;
    assign rd_idx = bit_reg[2:0];

    // the serial clock is a divided sys_clk, driven out by this end
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= H_IDLE;
            tick_reg <= 4'h0;
            bit_reg <= 4'h0;
            frame_reg <= 16'h0000;
            read_reg <= 1'b0;
            rd_shift_reg <= 8'h00;
            cs_n_reg <= 1'b1;
            sclk_reg <= 1'b0;
            sdi_reg <= 1'b0;
            edge_reg <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            done <= 1'b0;
            tick_reg <= tick_reg + 4'h1;
            unique case (state_reg)
                H_IDLE: begin
                    tick_reg <= 4'h0;
                    edge_reg <= edge_select_cfg;
                    if (req) begin
                        // select falls with command bit 0 already on the data line
                        frame_reg <= {req_wdata, 1'b0, PORT_ADDR, req_read};
                        read_reg <= req_read;
                        sdi_reg <= req_read;
                        bit_reg <= 4'h0;
                        cs_n_reg <= 1'b0;
                        busy <= 1'b1;
                        state_reg <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (half_done) begin
                        // data has stood a half period before this rise
                        sclk_reg <= 1'b1;
                        tick_reg <= 4'h0;
                        state_reg <= H_HIGH;
                        // select 1 output is sampled at the rise
                        if (edge_reg && read_reg && bit_reg >= FIRST_DATA_BIT) begin
                            rd_shift_reg[rd_idx] <= pin_sync[0];
                        end
                    end
                end
                H_HIGH: begin
                    if (half_done) begin
                        sclk_reg <= 1'b0;
                        tick_reg <= 4'h0;
                        // select 0 output is sampled at the fall
                        if (!edge_reg && read_reg && bit_reg >= FIRST_DATA_BIT) begin
                            rd_shift_reg[rd_idx] <= pin_sync[0];
                        end
                        if (bit_reg == LAST_BIT) begin
                            state_reg <= H_TAIL;
                        end else begin
                            bit_reg <= bit_reg + 4'h1;
                            sdi_reg <= frame_reg[bit_reg + 4'h1];
                            state_reg <= H_LOW;
                        end
                    end
                end
                H_TAIL: begin
                    // select rises well over 50 ns after the last rise
                    if (tick_reg == CS_HOLD_CYCLES - 4'h1) begin
                        cs_n_reg <= 1'b1;
                        tick_reg <= 4'h0;
                        state_reg <= H_GAP;
                    end
                end
                H_GAP: begin
                    // select stays high a half period before the next frame
                    if (half_done) begin
                        rd_data <= rd_shift_reg;
                        done <= 1'b1;
                        busy <= 1'b0;
                        state_reg <= H_IDLE;
                    end
                end
                default: begin
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

    // interrupt sensed inverted, so the synced reset value matches the idle line
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            int_active <= 1'b0;
        end else begin
            int_active <= pin_sync[1];
        end
    end

    assign port.cs_n = cs_n_reg;
    assign port.sclk = sclk_reg;
    assign port.serial_in_line = sdi_reg;
    assign port.edge_select = edge_reg;
endmodule : line_port_host
`default_nettype wire

//--- verif/serial_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_sva
    import serial_port_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_in_line,
    input wire logic edge_select,
    input wire logic serial_out_oe,
    input wire logic int_oe
);
    logic [4:0] cnt_reg;
    logic [7:0] cmd_reg;
    logic wr_reg;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // rises per frame; sclk is slow enough to oversample
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset || cs_n) begin
            cnt_reg <= 5'h00;
        end else if ($rose(sclk)) begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end
    // command byte, first bit lands in bit 0
    always_ff @(posedge sys_clk) begin
        if ($rose(sclk) && cnt_reg < 5'h08) begin
            cmd_reg <= {serial_in_line, cmd_reg[7:1]};
        end
    end
    // a complete write frame was seen
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset || $fell(cs_n)) begin
            wr_reg <= 1'b0;
        end else if ($rose(sclk) && cnt_reg == 5'h0F && !cmd_reg[0]) begin
            wr_reg <= 1'b1;
        end
    end
    oe_deselect_a: assert property (cs_n |-> !serial_out_oe)
        else $error("output driven while deselected");
    oe_cmd_a: assert property (serial_out_oe |-> cmd_reg[6:0] == {PORT_ADDR, CMD_READ})
        else $error("output driven outside addressed read");
    oe_window_a: assert property (serial_out_oe |-> cnt_reg >= 5'h08)
        else $error("output driven during command");
    read_drive_a: assert property (cnt_reg == 5'h0C && cmd_reg[6:0] == {PORT_ADDR, CMD_READ} |-> serial_out_oe)
        else $error("addressed read not driven");
    oe_hold_a: assert property (edge_select && cnt_reg == 5'h10 && !sclk |-> !serial_out_oe)
        else $error("output held past last fall");
    sdi_stable_a: assert property (sclk |-> $stable(serial_in_line))
        else $error("data changed while clock high");
    cs_hold_a: assert property ($rose(cs_n) |-> !sclk && !$past(sclk))
        else $error("select raised too early");
    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("clock running outside frame");
    int_clear_a: assert property ($fell(int_oe) |-> wr_reg)
        else $error("interrupt dropped without write");
endmodule : serial_port_sva
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import serial_port_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rx_clk = 1'b0;
    logic reset = 1'b1;
    logic req = 1'b0;
    logic req_read = 1'b0;
    logic [7:0] req_wdata = 8'h00;
    logic edge_select_cfg = 1'b1;
    logic signal_loss_in = 1'b1;
    logic driver_fault_in = 1'b0;
    logic rx_pos_in = 1'b0;
    logic busy, done, int_active, remote_loop_select, local_loop_select, all_ones_transmit;
    logic signal_loss_flag, driver_fault_flag, rx_positive_data, rx_negative_data;
    logic [7:0] rd_data;
    logic [2:0] line_length;
    integer error_cnt = 0;
    integer compares = 0;
    serial_port_if port_if ();
    line_port_host u_line_port_host (.sys_clk(sys_clk), .reset(reset), .port(port_if), .req(req),
        .req_read(req_read), .req_wdata(req_wdata), .edge_select_cfg(edge_select_cfg), .busy(busy),
        .done(done), .rd_data(rd_data), .int_active(int_active));
    line_port_device u_line_port_device (.sys_clk(sys_clk), .reset(reset), .port(port_if),
        .signal_loss_in(signal_loss_in), .driver_fault_in(driver_fault_in), .rx_clk(rx_clk), .rx_pos_in(rx_pos_in),
        .rx_neg_in(1'b0), .line_length(line_length), .remote_loop_select(remote_loop_select),
        .local_loop_select(local_loop_select), .all_ones_transmit(all_ones_transmit),
        .signal_loss_flag(signal_loss_flag), .driver_fault_flag(driver_fault_flag),
        .rx_positive_data(rx_positive_data), .rx_negative_data(rx_negative_data));
    serial_port_sva u_serial_port_sva (.sys_clk(sys_clk), .reset(reset), .cs_n(port_if.cs_n),
        .sclk(port_if.sclk), .serial_in_line(port_if.serial_in_line), .edge_select(port_if.edge_select),
        .serial_out_oe(port_if.serial_out_oe), .int_oe(port_if.int_oe));
    // 20 MHz system clock; link clock offset so the phases never line up
    always #25 sys_clk = ~sys_clk;
    initial begin
        #3.3;
        forever #6 rx_clk = ~rx_clk;
    end
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one host transfer; done is bounded so a hang ends the run
    task automatic xfer(input logic rd, input logic [7:0] wd);
        int n;
        n = 0;
        @(negedge sys_clk);
        req = 1'b1;
        req_read = rd;
        req_wdata = wd;
        @(negedge sys_clk);
        req = 1'b0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 400) begin
            $display("Error %0t: transfer timed out", $time);
            error_cnt++;
            tally_and_finish;
        end
    endtask : xfer
    // interrupt path needs sync plus a few cycles to settle
    task automatic wt;
        repeat (30) @(negedge sys_clk);
    endtask : wt
    task automatic t_ones;
        xfer(1'b0, 8'h9C);
        chk(8'(line_length), 8'h07);
        chk({6'h00, remote_loop_select, all_ones_transmit}, 8'h01);
        xfer(1'b1, 8'h00);
        chk(rd_data, 8'h9D);
    endtask : t_ones
    task automatic t_local;
        edge_select_cfg = 1'b0;
        xfer(1'b0, 8'h48);
        chk(8'(local_loop_select), 8'h01);
        xfer(1'b1, 8'h00);
        chk(rd_data, 8'h49);
        edge_select_cfg = 1'b1;
    endtask : t_local
    task automatic t_int;
        signal_loss_in = 1'b0;
        wt;
        chk(8'(int_active), 8'h01);
        xfer(1'b1, 8'h00);
        chk(rd_data, 8'h68);
        chk(8'(int_active), 8'h01);
        xfer(1'b0, 8'h09);
        wt;
        chk(8'(int_active), 8'h00);
        signal_loss_in = 1'b1;
        wt;
        chk(8'(int_active), 8'h00);
        xfer(1'b1, 8'h00);
        chk(rd_data, 8'h09);
        xfer(1'b0, 8'h08);
        signal_loss_in = 1'b0;
        wt;
        chk(8'(int_active), 8'h01);
        driver_fault_in = 1'b1;
        wt;
        xfer(1'b1, 8'h00);
        chk(rd_data, 8'hEA);
    endtask : t_int
    task automatic t_dreset;
        xfer(1'b0, 8'h6C);
        xfer(1'b1, 8'h00);
        chk(rd_data, 8'h01);
        chk({signal_loss_flag, driver_fault_flag, 3'h0, line_length}, 8'h80);
    endtask : t_dreset
    // main sequence
    initial begin
        repeat (12) @(negedge sys_clk);
        reset = 1'b0;
        t_ones;
        t_local;
        t_int;
        t_dreset;
        rx_pos_in = 1'b1;
        wt;
        chk(8'(rx_positive_data), 8'h01);
        tally_and_finish;
    end
endmodule : testbench
`default_nettype wire
